// [logic/bih_defs.svh]
// constants for the bidding interrupt arbiter and its host port
// assumes nothing beyond a single 100 MHz clock domain
`ifndef BIH_DEFS_SVH
`define BIH_DEFS_SVH

`define BIH_ADDR_IVR_W      8'h0C
`define BIH_ADDR_ICR_W      8'h0D
`define BIH_ADDR_CIR_W      8'h0E
`define BIH_ADDR_MASK01     8'h0F
`define BIH_ADDR_MASK23     8'h10
`define BIH_ADDR_GBYTE      8'h11
`define BIH_ADDR_GCHAN      8'h12
`define BIH_ADDR_GRX        8'h13
`define BIH_ADDR_GTX        8'h14
`define BIH_ADDR_DACK_OFF   8'h26
`define BIH_ADDR_DACK_ON    8'h27
`define BIH_ADDR_UPD_CIR    8'h2A

`define BIH_TYPE_RX_ERR     3'h7
`define BIH_TYPE_RX_OK      3'h3
`define BIH_TYPE_TX         3'h2
`define BIH_TYPE_BRK        3'h4
`define BIH_TYPE_COS        3'h1
`define BIH_TYPE_CT         3'h5
`define BIH_TYPE_NONE       3'h0

`define BIH_FMT_FULL        2'h0
`define BIH_FMT_CHAN        2'h1
`define BIH_FMT_TYPE        2'h2
`define BIH_FMT_INHIBIT     2'h3

`define BIH_RST_IVR         8'h0F
`define BIH_RST_ICR         8'hFC
`define BIH_RST_MASK        9'h000
`define BIH_DACK_EDGES      2'h2
`define BIH_FIFO_FULL       4'h8

`endif

// [logic/bih_pkg.sv]
// types shared by the bidding interrupt host port
// assumes bih_defs.svh holds all numeric constants
`default_nettype none
package bih_pkg;
    typedef struct packed {
        logic [3:0] rx_count;
        logic [3:0] tx_count;
        logic       rx_error;
        logic       break_detect;
        logic       change_of_state;
        logic [1:0] rx_level;
        logic [1:0] tx_level;
        logic [2:0] rx_prog;
        logic [1:0] brk_prog;
        logic [1:0] cos_prog;
    } bih_chan_t;

    typedef struct packed {
        logic       timed_out;
        logic [1:0] prog;
    } bih_timer_t;

    typedef enum logic [1:0] {
        BIH_IDLE = 2'b00,
        BIH_WAIT = 2'b01,
        BIH_ACK  = 2'b10
    } bih_state_t;
endpackage
`default_nettype wire

// [logic/bih_host_port.sv]
// bidding interrupt arbiter with its host bus port
// assumes channel status arrives from the serial channels on ref_clk
`include "bih_defs.svh"
`default_nettype none

module bih_host_port
    import bih_pkg::*;
#(
    parameter int CHANNELS = 4
) (
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    input  wire logic             chip_select_n,
    input  wire logic             read_strobe_n,
    input  wire logic             write_strobe_n,
    input  wire logic             intr_ack_n,
    input  wire logic [7:0]       addr,
    input  wire logic [7:0]       data_in,
    output logic      [7:0]       data_out,
    output logic                  data_oe,
    output logic                  intr_request_n,
    output logic                  intr_request_oe,
    output logic                  data_ack_n,
    output logic                  data_ack_oe,
    input  wire bih_chan_t [3:0]  chan,
    input  wire bih_timer_t [1:0] timer,
    input  wire logic [7:0]       rx_fifo_data,
    output logic      [1:0]       rx_pop_chan,
    output logic                  rx_pop,
    output logic      [1:0]       tx_push_chan,
    output logic                  tx_push,
    output logic      [7:0]       tx_push_data
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic [3:0] pin_prev;
    logic [7:0] addr_meta, addr_s, din_meta, din_s;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pin_meta  <= 4'hF;
            pin_sync  <= 4'hF;
            pin_prev  <= 4'hF;
            addr_meta <= 8'h00;
            addr_s    <= 8'h00;
            din_meta  <= 8'h00;
            din_s     <= 8'h00;
        end else begin
            pin_meta  <= {intr_ack_n, write_strobe_n, read_strobe_n,
                          chip_select_n};
            pin_sync  <= pin_meta;
            pin_prev  <= pin_sync;
            addr_meta <= addr;
            addr_s    <= addr_meta;
            din_meta  <= data_in;
            din_s     <= din_meta;
        end
    end

    // active-high views of the synchronised strobes
    logic cs, rd, wr, ia, wr_prev, cyc, cyc_prev;
    assign cs       = ~pin_sync[0];
    assign rd       = cs & ~pin_sync[1];
    assign wr       = cs & ~pin_sync[2];
    assign ia       = ~pin_sync[3];
    assign wr_prev  = ~pin_prev[0] & ~pin_prev[2];
    assign cyc      = rd | wr | ia;
    assign cyc_prev = (~pin_prev[0] & (~pin_prev[1] | ~pin_prev[2]))
                      | ~pin_prev[3];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] vector_base;
    logic [7:0] interrupt_threshold_format;
    logic [7:0] captured_interrupt;
    logic [8:0] source_bid_mask [2];
    logic       dack_enable;

    // ------------------------------------------------------------
    // bid arbitration
    // ------------------------------------------------------------
    function automatic logic [7:0] bid(input logic [2:0] upper,
                                       input logic [2:0] kind,
                                       input logic [1:0] ch);
        bid = {upper, kind, ch};
    endfunction

    function automatic logic level_ok(input logic [1:0] lvl,
                                      input logic [3:0] fill);
        // level n asks for at least 2n bytes, zero only excludes the limit
        level_ok = (lvl == 2'h0) || (fill >= {1'b0, lvl, 1'b0});
    endfunction

    logic [7:0] win_bid;
    logic [7:0] cand;
    logic [3:0] rcnt;
    logic [8:0] m;

    always_comb begin
        win_bid = 8'h00;
        cand    = 8'h00;
        rcnt    = 4'h0;
        m       = 9'h000;
        // the channel number forms the low bid bits, so on equal priority the highest channel wins
        for (int c = 0; c < CHANNELS; c++) begin
            m    = source_bid_mask[c / 2];
            rcnt = (chan[c].rx_count == `BIH_FIFO_FULL) ? 4'h7
                                                        : chan[c].rx_count;
            if (m[(c % 2) * 4] && chan[c].rx_count != 4'h0 &&
                level_ok(chan[c].rx_level, chan[c].rx_count)) begin
                // two bytes per count step keeps bit 7 set for receivers
                cand = bid({1'b1, rcnt[2:1]},
                           chan[c].rx_error ? `BIH_TYPE_RX_ERR
                                            : `BIH_TYPE_RX_OK,
                           2'(c));
                if (cand >= win_bid)
                    win_bid = cand;
            end
            if (m[(c % 2) * 4 + 1] && chan[c].tx_count != `BIH_FIFO_FULL &&
                level_ok(chan[c].tx_level,
                         4'(`BIH_FIFO_FULL - chan[c].tx_count))) begin
                cand = bid(3'(`BIH_FIFO_FULL - chan[c].tx_count - 4'h1),
                           `BIH_TYPE_TX, 2'(c));
                if (cand >= win_bid)
                    win_bid = cand;
            end
            if (m[(c % 2) * 4 + 2] && chan[c].break_detect) begin
                cand = bid({1'b0, chan[c].brk_prog}, `BIH_TYPE_BRK, 2'(c));
                if (cand >= win_bid)
                    win_bid = cand;
            end
            if (m[(c % 2) * 4 + 3] && chan[c].change_of_state) begin
                cand = bid({1'b0, chan[c].cos_prog}, `BIH_TYPE_COS, 2'(c));
                if (cand >= win_bid)
                    win_bid = cand;
            end
        end
        for (int t = 0; t < 2; t++) begin
            if (source_bid_mask[t][8] && timer[t].timed_out) begin
                cand = bid({timer[t].prog, 1'b0}, `BIH_TYPE_CT,
                           2'(t * 2 + 1));
                if (cand >= win_bid)
                    win_bid = cand;
            end
        end
    end

    // channel bits sit below the compare window, so they never qualify
    logic above;
    assign above = win_bid[7:2]
                   > interrupt_threshold_format[7:2];

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            intr_request_n  <= 1'b1;
            intr_request_oe <= 1'b0;
        end else begin
            intr_request_n  <= 1'b0;
            intr_request_oe <= above;
        end
    end

    // ------------------------------------------------------------
    // bus cycle sequencing
    // ------------------------------------------------------------
    bih_state_t state;
    logic [1:0] edge_cnt;
    logic       stored;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state    <= BIH_IDLE;
            edge_cnt <= 2'h0;
        end else begin
            case (state)
                BIH_IDLE: begin
                    if (cyc && !cyc_prev) begin
                        state    <= BIH_WAIT;
                        edge_cnt <= 2'h1;
                    end
                end
                BIH_WAIT: begin
                    if (!cyc)
                        state <= BIH_IDLE;
                    else if (edge_cnt == `BIH_DACK_EDGES)
                        state <= BIH_ACK;
                    else
                        edge_cnt <= edge_cnt + 2'h1;
                end
                BIH_ACK: begin
                    if (!cyc)
                        state <= BIH_IDLE;
                end
                default: state <= BIH_IDLE;
            endcase
        end
    end

    // acked writes store one cycle before the ack is driven; otherwise at strobe end
    logic do_write, ia_start;
    assign do_write = dack_enable
        ? ((state == BIH_WAIT && edge_cnt == `BIH_DACK_EDGES && wr) ||
           (wr_prev && !wr && !stored))
        : (wr_prev && !wr);
    assign ia_start = ia & pin_prev[3];

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            stored <= 1'b0;
        else if (!cyc)
            stored <= 1'b0;
        else if (do_write)
            stored <= 1'b1;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            data_ack_n  <= 1'b1;
            data_ack_oe <= 1'b0;
        end else begin
            data_ack_n  <= 1'b0;
            data_ack_oe <= dack_enable && state == BIH_ACK
                           && cyc;
        end
    end

    // ------------------------------------------------------------
    // register writes and capture
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            vector_base                <= `BIH_RST_IVR;
            interrupt_threshold_format <= `BIH_RST_ICR;
            source_bid_mask[0]         <= `BIH_RST_MASK;
            source_bid_mask[1]         <= `BIH_RST_MASK;
            dack_enable                <= 1'b1;
        end else if (do_write) begin
            case (addr_s)
                `BIH_ADDR_IVR_W:    vector_base <= din_s;
                `BIH_ADDR_ICR_W:
                    interrupt_threshold_format <= din_s;
                `BIH_ADDR_MASK01:   source_bid_mask[0] <= {din_s[0], din_s};
                `BIH_ADDR_MASK23:   source_bid_mask[1] <= {din_s[0], din_s};
                `BIH_ADDR_DACK_OFF: dack_enable <= 1'b0;
                `BIH_ADDR_DACK_ON:  dack_enable <= 1'b1;
                default: ;
            endcase
        end
    end

    // only acknowledge or the update command loads it
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            captured_interrupt <= 8'h00;
        else if (ia_start ||
                 (do_write && addr_s == `BIH_ADDR_UPD_CIR))
            captured_interrupt <= win_bid;
    end

    // ------------------------------------------------------------
    // read data, vector and global registers
    // ------------------------------------------------------------
    function automatic logic [7:0] vector(input logic [7:0] base,
                                          input logic [1:0] fmt,
                                          input logic [7:0] cap);
        case (fmt)
            `BIH_FMT_FULL: vector = base;
            `BIH_FMT_CHAN: vector = {base[7:2], cap[1:0]};
            `BIH_FMT_TYPE: vector = {base[7:5], cap[4:2], cap[1:0]};
            default:       vector = 8'hFF;
        endcase
    endfunction

    logic [7:0] next_data;
    always_comb begin
        case (addr_s)
            `BIH_ADDR_IVR_W: next_data = vector_base;
            `BIH_ADDR_ICR_W: next_data = interrupt_threshold_format;
            `BIH_ADDR_CIR_W: next_data = captured_interrupt;
            `BIH_ADDR_MASK01: next_data = source_bid_mask[0][7:0];
            `BIH_ADDR_MASK23: next_data = source_bid_mask[1][7:0];
            `BIH_ADDR_GBYTE: next_data = {5'h00, captured_interrupt[7:5]};
            `BIH_ADDR_GCHAN: next_data = {6'h00, captured_interrupt[1:0]};
            `BIH_ADDR_GRX:   next_data = rx_fifo_data;
            default:         next_data = 8'h00;
        endcase
    end

    // vector follows the register just loaded, hence one cycle late
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            data_out <= 8'h00;
            data_oe  <= 1'b0;
        end else if (ia) begin
            data_out <= vector(vector_base, interrupt_threshold_format[1:0],
                               captured_interrupt);
            data_oe  <= 1'b1;
        end else begin
            data_out <= next_data;
            data_oe  <= rd;
        end
    end

    // pops on each release of a read strobe addressed to GRX, so a long strobe costs one byte
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rx_pop       <= 1'b0;
            rx_pop_chan  <= 2'h0;
            tx_push      <= 1'b0;
            tx_push_chan <= 2'h0;
            tx_push_data <= 8'h00;
        end else begin
            rx_pop       <= !pin_prev[0] & !pin_prev[1] & !rd
                            & addr_s == `BIH_ADDR_GRX;
            rx_pop_chan  <= captured_interrupt[1:0];
            tx_push      <= do_write && addr_s == `BIH_ADDR_GTX;
            tx_push_chan <= captured_interrupt[1:0];
            tx_push_data <= din_s;
        end
    end
endmodule
`default_nettype wire

// [verif/bih_port_assertions.sv]
// concurrent checks on the host pins of bih_host_port
// assumes the host holds strobes low until acknowledge
`default_nettype none
module bih_port_checker (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic chip_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic intr_ack_n,
    input wire logic data_oe,
    input wire logic intr_request_n,
    input wire logic intr_request_oe,
    input wire logic data_ack_n,
    input wire logic data_ack_oe,
    input wire logic rx_pop,
    input wire logic tx_push
);
    // ----------------------------------------
    // pin decode
    // ----------------------------------------
    logic       rd_c;
    logic       wr_c;
    logic       cyc;
    logic [4:0] rd_hist;
    assign rd_c = (!chip_select_n && !read_strobe_n) || !intr_ack_n;
    assign wr_c = !chip_select_n && !write_strobe_n;
    assign cyc  = rd_c || wr_c;
    // bus drive lags the pins by two sync flops and the output flop, so keep a short history
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rd_hist <= 5'h00;
        end else begin
            rd_hist <= {rd_hist[3:0], rd_c};
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    sequence s_start;
        $rose(cyc);
    endsequence
    sequence s_no_ack;
        !data_ack_oe [*2];
    endsequence
    property p_irq_od;
        intr_request_oe |-> !intr_request_n;
    endproperty
    a_irq_od: assert property (p_irq_od)
        else $error("request high");
    property p_ack_od;
        data_ack_oe |-> !data_ack_n;
    endproperty
    a_ack_od: assert property (p_ack_od)
        else $error("ack high");
    property p_ack_late;
        s_start |-> s_no_ack;
    endproperty
    a_ack_late: assert property (p_ack_late)
        else $error("ack early");
    property p_ack_cause;
        $rose(data_ack_oe) |-> $past(cyc, 1) && $past(cyc, 2);
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack no cycle");
    property p_ack_drop;
        $fell(cyc) |-> ##[1:5] !data_ack_oe;
    endproperty
    a_ack_drop: assert property (p_ack_drop)
        else $error("ack stuck");
    property p_oe_cause;
        data_oe |-> rd_c || (|rd_hist);
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("stray drive");
    property p_no_oe_wr;
        wr_c [*6] |-> !data_oe;
    endproperty
    a_no_oe_wr: assert property (p_no_oe_wr)
        else $error("drive in write");
    property p_rx_pop;
        rx_pop |-> (rd_c || (|rd_hist)) ##1 !rx_pop;
    endproperty
    a_rx_pop: assert property (p_rx_pop)
        else $error("bad pop");
    property p_tx_push;
        tx_push |=> !tx_push;
    endproperty
    a_tx_push: assert property (p_tx_push)
        else $error("long push");
endmodule
bind bih_host_port bih_port_checker i_bih_port_checker (
    .ref_clk, .rstn, .chip_select_n, .read_strobe_n, .write_strobe_n,
    .intr_ack_n, .data_oe, .intr_request_n, .intr_request_oe,
    .data_ack_n, .data_ack_oe, .rx_pop, .tx_push
);
`default_nettype wire

// [verif/bih_host_model.sv]
// host processor bus model: read, write and acknowledge cycles
// assumes strobes move on falling edges and ack is sampled on rising
`default_nettype none
module bih_host_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    input  wire logic       data_ack_oe,
    output var  logic       chip_select_n,
    output var  logic       read_strobe_n,
    output var  logic       write_strobe_n,
    output var  logic       intr_ack_n,
    output var  logic [7:0] addr,
    output wire logic [7:0] data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       drv;
    logic       ack_en;
    logic [7:0] wd;
    logic [7:0] last;
    int         misses;
    // undriven bus toggles so a stale byte never reads as a match
    assign data_in = data_oe ? data_out : (drv ? wd : ~last);
    always @(posedge ref_clk) last <= data_in;
    initial begin
        {chip_select_n, read_strobe_n, write_strobe_n, intr_ack_n} = 4'hF;
        addr = 8'h00;
        drv = 1'b0;
        ack_en = 1'b1;
        wd = 8'h00;
        last = 8'h00;
        misses = 0;
    end
    // kind 0 read, 1 write, 2 interrupt acknowledge
    task automatic cyc(input logic [1:0] k, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(negedge ref_clk);
        addr = a;
        wd = d;
        drv = (k == 2'h1);
        chip_select_n = (k == 2'h2);
        read_strobe_n = (k != 2'h0);
        write_strobe_n = (k != 2'h1);
        intr_ack_n = (k != 2'h2);
        // the write that turns ack off is itself never acknowledged
        if (k == 2'h1 && a == 8'h26) ack_en = 1'b0;
        if (ack_en) begin
            do begin
                @(posedge ref_clk);
                n++;
            end while (!data_ack_oe && n < 20);
            if (!data_ack_oe) misses++;
        end else begin
            repeat (8) @(posedge ref_clk);
        end
        q = data_out;
        @(negedge ref_clk);
        {chip_select_n, read_strobe_n, write_strobe_n, intr_ack_n} = 4'hF;
        if (k == 2'h1 && a == 8'h27) ack_en = 1'b1;
        repeat (2) @(negedge ref_clk);
        drv = 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench for bih_host_port driven by a host bus model
// assumes the offsets and reset values of bih_defs.svh
`include "bih_defs.svh"
`default_nettype none
module tb_top
    import bih_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [1:0] k;
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } bih_row_t;
    localparam bih_row_t ROWS [17] = '{
        '{2'h0, 8'h0C, 8'h00, 8'h0F}, '{2'h0, 8'h0D, 8'h00, 8'hFC},
        '{2'h0, 8'h0E, 8'h00, 8'h00}, '{2'h0, 8'h30, 8'h00, 8'h00},
        '{2'h1, 8'h0C, 8'hF0, 8'h00}, '{2'h1, 8'h10, 8'h08, 8'h00},
        '{2'h1, 8'h0D, 8'h00, 8'h00}, '{2'h0, 8'h0E, 8'h00, 8'h00},
        '{2'h2, 8'h00, 8'h00, 8'hF0}, '{2'h0, 8'h0E, 8'h00, 8'h66},
        '{2'h0, 8'h12, 8'h00, 8'h02}, '{2'h1, 8'h0D, 8'h01, 8'h00},
        '{2'h2, 8'h00, 8'h00, 8'hF2}, '{2'h1, 8'h0D, 8'h02, 8'h00},
        '{2'h2, 8'h00, 8'h00, 8'hE6}, '{2'h1, 8'h0D, 8'h03, 8'h00},
        '{2'h2, 8'h00, 8'h00, 8'hFF}
    };
    logic             ref_clk;
    logic             rstn;
    logic             chip_select_n;
    logic             read_strobe_n;
    logic             write_strobe_n;
    logic             intr_ack_n;
    logic [7:0]       addr;
    logic [7:0]       data_in;
    logic [7:0]       data_out;
    logic             data_oe;
    logic             intr_request_n;
    logic             intr_request_oe;
    logic             data_ack_n;
    logic             data_ack_oe;
    bih_chan_t  [3:0] chan;
    bih_timer_t [1:0] timer;
    logic [7:0]       rx_fifo_data;
    logic [1:0]       rx_pop_chan;
    logic             rx_pop;
    logic [1:0]       tx_push_chan;
    logic             tx_push;
    logic [7:0]       tx_push_data;
    logic [7:0]       q;
    int               failures = 0;
    int               num_checks = 0;
    int               cycles = 0;
    int               acks = 0;
    int               pops = 0;
    logic [7:0]       push_data;
    bih_host_port i_bih_host_port (
        .ref_clk, .rstn, .chip_select_n, .read_strobe_n, .write_strobe_n,
        .intr_ack_n, .addr, .data_in, .data_out, .data_oe, .intr_request_n,
        .intr_request_oe, .data_ack_n, .data_ack_oe, .chan, .timer,
        .rx_fifo_data, .rx_pop_chan, .rx_pop, .tx_push_chan, .tx_push,
        .tx_push_data
    );
    bih_host_model i_bih_host_model (
        .ref_clk, .data_out, .data_oe, .data_ack_oe, .chip_select_n,
        .read_strobe_n, .write_strobe_n, .intr_ack_n, .addr, .data_in
    );
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // a hang cuts the run short with a counted mismatch
    always @(posedge ref_clk) begin
        cycles++;
        if (data_ack_oe) acks++;
        if (rx_pop) pops++;
        if (tx_push) push_data <= tx_push_data;
        if (cycles == 5000) begin
            failures++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [7:0] s,
                       input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic [1:0] k, input logic [7:0] a,
                       input logic [7:0] d);
        i_bih_host_model.cyc(k, a, d, q);
    endtask
    task automatic irq(input logic e);
        repeat (8) @(negedge ref_clk);
        chk("irq", {7'h00, intr_request_oe}, {7'h00, e});
    endtask
    task automatic stop_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        rstn = 1'b0;
        chan = '0;
        timer = '0;
        rx_fifo_data = 8'h3C;
        chan[2].change_of_state = 1'b1;
        chan[2].cos_prog = 2'h3;
        repeat (3) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (3) @(negedge ref_clk);
        foreach (ROWS[i]) begin
            bus(ROWS[i].k, ROWS[i].a, ROWS[i].d);
            if (ROWS[i].k != 2'h1) chk("row", q, ROWS[i].e);
        end
        irq(1'b1);
        bus(2'h1, 8'h0D, 8'h64);
        irq(1'b0);
        bus(2'h1, 8'h0D, 8'h60);
        irq(1'b1);
        chan[1].change_of_state = 1'b1;
        chan[1].cos_prog = 2'h3;
        chan[3] = chan[1];
        bus(2'h1, 8'h0F, 8'h80);
        bus(2'h1, 8'h10, 8'h88);
        bus(2'h1, 8'h2A, 8'h00);
        bus(2'h0, 8'h0E, 8'h00);
        chk("cir", q, 8'h67);
        chan[3].change_of_state = 1'b0;
        bus(2'h0, 8'h0E, 8'h00);
        chk("cir", q, 8'h67);
        bus(2'h1, 8'h2A, 8'h00);
        bus(2'h0, 8'h0E, 8'h00);
        chk("cir", q, 8'h66);
        chan[1].change_of_state = 1'b0;
        chan[2].change_of_state = 1'b0;
        chan[0].tx_count = 4'h8;
        bus(2'h1, 8'h0D, 8'h00);
        bus(2'h1, 8'h10, 8'h00);
        bus(2'h1, 8'h0F, 8'h02);
        irq(1'b0);
        chan[0].tx_count = 4'h7;
        irq(1'b1);
        chan[0].tx_count = 4'h0;
        bus(2'h1, 8'h0F, 8'h01);
        irq(1'b0);
        timer[0].timed_out = 1'b1;
        irq(1'b1);
        timer[0].timed_out = 1'b0;
        chan[0].rx_level = 2'h1;
        chan[0].rx_count = 4'h1;
        irq(1'b0);
        chan[0].rx_count = 4'h2;
        irq(1'b1);
        bus(2'h1, 8'h2A, 8'h00);
        bus(2'h0, 8'h0E, 8'h00);
        chk("cir", q, 8'hAC);
        bus(2'h0, 8'h11, 8'h00);
        chk("gbyte", q, 8'h05);
        bus(2'h0, 8'h13, 8'h00);
        chk("grx", q, 8'h3C);
        chk("pops", pops[7:0], 8'h01);
        bus(2'h1, 8'h14, 8'h77);
        chk("push", push_data, 8'h77);
        bus(2'h1, 8'h26, 8'h00);
        acks = 0;
        bus(2'h1, 8'h0C, 8'h3C);
        bus(2'h0, 8'h0C, 8'h00);
        chk("ivr", q, 8'h3C);
        chk("acks", acks[7:0], 8'h00);
        bus(2'h1, 8'h27, 8'h00);
        bus(2'h0, 8'h0D, 8'h00);
        chk("icr", q, 8'h00);
        bus(2'h1, 8'h26, 8'h00);
        rstn = 1'b0;
        repeat (3) @(negedge ref_clk);
        rstn = 1'b1;
        i_bih_host_model.ack_en = 1'b1;
        repeat (3) @(negedge ref_clk);
        bus(2'h0, 8'h0D, 8'h00);
        chk("icr", q, 8'hFC);
        chk("miss", i_bih_host_model.misses[7:0], 8'h00);
        stop_test();
    end
endmodule
`default_nettype wire
